// ===== bench/bis_host_model.sv
// Host model: sends the sync character 0x7F, 8E1, on each serial line selected in go.
// Assumes go is held one pclk cycle; both lines idle high otherwise.
`timescale 1ns/1ps
`default_nettype none
module bis_host_model #(
   parameter int BIT = 20
) (
   input  wire logic       pclk,
   input  wire logic [1:0] go,
   output var  logic [1:0] rx,
   output var  logic       busy
);
   // Start, seven ones, a zero, even parity, stop
   localparam logic [10:0] FRM = 11'h6FE;
   logic [1:0] sel;
   // Unused receive lines held at a fixed high level
   initial rx = 2'b11;
   initial busy = 1'b0;
   initial sel = 2'b00;
   // One frame per request, BIT cycles a bit
   always begin
      @(posedge pclk);
      if (go != 2'b00) begin
         sel = go;
         busy <= 1'b1;
         for (int i = 0; i < 11; i++) begin
            rx <= FRM[i] ? 2'b11 : ~sel;
            repeat (BIT) @(posedge pclk);
         end
         rx <= 2'b11;
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== bench/bis_top_monitor.sv
// Checker bound onto bis_top: link selection, framing, APB timing.
// Assumes one pclk domain and presetn active low.
`timescale 1ns/1ps
`default_nettype none
module bis_top_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        usb_attach,
   input wire logic        ext_clock_ok,
   input wire logic        system_reset_req,
   input wire logic        loader_mode_r,
   input wire logic        first_serial_en_r,
   input wire logic        second_serial_en_r,
   input wire logic        usb_en_r,
   input wire logic [1:0]  prot_level_r,
   input wire logic [7:0]  serial_frame_cfg_r
);
   wire [2:0] en;
   wire       wr_ctl;
   // Enables in link-code order, completed control writes
   assign en = {usb_en_r, second_serial_en_r, first_serial_en_r};
   assign wr_ctl = psel && penable && pready && pwrite && paddr == 12'h000;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   idle_off_a: assert property (
      !loader_mode_r |-> en == 3'h0) else $error("link on outside loader");
   usb_pick_a: assert property (
      en == 3'h7 && usb_attach && ext_clock_ok && !system_reset_req
      |=> en == 3'h4) else $error("usb attach not selected");
   ser_hold_a: assert property (
      (en == 3'h1 || en == 3'h2) && !system_reset_req |=> $stable(en))
      else $error("serial session disturbed");
   frame_cfg_a: assert property (
      serial_frame_cfg_r != 8'h00 |-> serial_frame_cfg_r == 8'h78)
      else $error("bad serial frame setting");
   rdy_wait_a: assert property (
      psel && !penable |-> !pready ##1 pready)
      else $error("pready not in first access cycle");
   rdy_pulse_a: assert property (
      pready |-> psel && penable ##1 !pready) else $error("pready misplaced");
   prot_set_a: assert property (
      wr_ctl && pwdata[1] |=> prot_level_r == 2'h1)
      else $error("protect did not give level 1");
   prot_clr_a: assert property (
      wr_ctl && pwdata[2] && !pwdata[1] |=> prot_level_r == 2'h0)
      else $error("unprotect did not give level 0");
   cover property (en == 3'h4);
   cover property (en == 3'h2);
   cover property (wr_ctl && pwdata[1]);
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the boot interface selector.
// Assumes bis_top, the host model and the monitor are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "bis_map.vh"
module tb;
   localparam int BIT = 20;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic boot_select_pin = 1, usb_attach = 0, ext_clock_ok = 0;
   logic system_reset_req = 0, pready, pslverr, err, loader, busy;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   wire  [2:0]  en;
   logic [1:0]  rx, prot, go = 0;
   logic [7:0]  cfg;
   int          miscompares = 0, num_checks = 0;

   bis_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_select_pin(boot_select_pin), .first_serial_receive(rx[0]),
      .second_serial_receive(rx[1]), .usb_attach(usb_attach),
      .ext_clock_ok(ext_clock_ok), .system_reset_req(system_reset_req),
      .loader_mode_r(loader), .first_serial_en_r(en[0]),
      .second_serial_en_r(en[1]), .usb_en_r(en[2]),
      .prot_level_r(prot), .serial_frame_cfg_r(cfg));
   bis_host_model #(.BIT(BIT)) host (.pclk(pclk), .go(go), .rx(rx),
      .busy(busy));

   // 10 MHz clock
   always #50 pclk = ~pclk;

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer, then one idle edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Strap check again, then polling or application state
   task automatic restart;
      system_reset_req <= 1'b1;
      @(posedge pclk);
      system_reset_req <= 1'b0;
      tick(4);
   endtask
   // Host pulses device reset; boot pin is sampled after it
   task automatic pulse_reset;
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      tick(3);
   endtask
   // Host sends one sync frame on the lines in g
   task automatic send(input logic [1:0] g);
      int n;
      n = 0;
      go <= g;
      @(posedge pclk);
      go <= 2'b00;
      tick(2);
      while (busy && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 1000) begin
         miscompares++;
         finish_test();
      end
      tick(3);
   endtask
   task automatic t_poll;
      chk(loader, 1'b1);
      chk(en, 3'h7);
      apb(0, `BIS_OPT_OFF, 0);
      chk(rd, 32'h0000_0001);
      usb_attach <= 1'b1;
      tick(5);
      chk(en, 3'h7);
      $display("test poll done");
   endtask
   task automatic t_usb;
      ext_clock_ok <= 1'b1;
      tick(3);
      chk(en, `BIS_LINK_USB);
      send(2'b01);
      chk(en, `BIS_LINK_USB);
      apb(0, `BIS_STAT_OFF, 0);
      chk(rd[3:0], 4'h9);
      usb_attach <= 1'b0;
      $display("test usb done");
   endtask
   task automatic t_ser;
      restart();
      send(2'b10);
      chk(en, `BIS_LINK_SER2);
      chk(cfg, 8'h78);
      apb(0, `BIS_BAUD_OFF, 0);
      chk(rd, BIT);
      usb_attach <= 1'b1;
      send(2'b01);
      chk(en, `BIS_LINK_SER2);
      usb_attach <= 1'b0;
      restart();
      send(2'b01);
      chk(en, `BIS_LINK_SER1);
      $display("test serial done");
   endtask
   task automatic t_prot;
      apb(1, `BIS_CTRL_OFF, 32'h0000_0002);
      chk(prot, `BIS_PROT_L1);
      apb(1, `BIS_CTRL_OFF, 32'h0000_0004);
      apb(0, `BIS_PROT_OFF, 0);
      chk(rd, 32'h0000_0000);
      apb(1, `BIS_STAT_OFF, 32'h0000_0001);
      chk(err, 1'b1);
      apb(0, 12'h020, 0);
      chk(err, 1'b1);
      $display("test protection done");
   endtask
   task automatic t_boot;
      apb(1, `BIS_OPT_OFF, 0);
      restart();
      chk({loader, en}, 4'h0);
      // Application state: remap and vector moves are its own
      apb(1, `BIS_OPT_OFF, 32'h0000_0001);
      boot_select_pin <= 1'b0;
      pulse_reset();
      chk({loader, en}, 4'h0);
      apb(0, `BIS_OPT_OFF, 0);
      chk(rd, 32'h0000_0001);
      boot_select_pin <= 1'b1;
      pulse_reset();
      chk({loader, en}, 4'hF);
      $display("test boot entry done");
   endtask

   // Reset, then the scenarios in turn
   initial begin
      tick(12);
      presetn <= 1'b1;
      tick(3);
      t_poll();
      t_usb();
      t_ser();
      t_prot();
      t_boot();
      finish_test();
   end
endmodule
bind bis_top bis_top_monitor mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .usb_attach(usb_attach),
   .ext_clock_ok(ext_clock_ok), .system_reset_req(system_reset_req),
   .loader_mode_r(loader_mode_r), .first_serial_en_r(first_serial_en_r),
   .second_serial_en_r(second_serial_en_r), .usb_en_r(usb_en_r),
   .prot_level_r(prot_level_r), .serial_frame_cfg_r(serial_frame_cfg_r));
`default_nettype wire

// ===== design/bis_auto_baud.v
// One serial receive watcher: times the sync character and reports it.
// Assumes the receive line is synchronous to pclk and idles high.
`timescale 1ns/1ps
`default_nettype none
`include "bis_map.vh"

module bis_auto_baud (
   input  wire                  pclk,
   input  wire                  presetn,
   input  wire                  enable,
   input  wire                  rx,
   output reg                   found_r,
   output reg  [`BIS_CNT_W-1:0] bit_cyc_r
);

   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_LOW  = 4'b0010;
   localparam [3:0] S_HIGH = 4'b0100;
   localparam [3:0] S_DONE = 4'b1000;

   reg  [3:0]            state_r;
   reg  [3:0]            state_nxt;
   reg  [`BIS_CNT_W-1:0] cnt_r;
   reg  [`BIS_CNT_W-1:0] low_r;
   reg                   rx_d_r;
   wire                  fall;
   wire                  rise;

   assign fall = rx_d_r & ~rx;
   assign rise = ~rx_d_r & rx;

   // Sync char 0x7F: start bit plus seven ones give one low bit, then
   // a long high run; the low run is one bit period
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: if (enable && fall) state_nxt = S_LOW;
         S_LOW: begin
            if (rise)
               state_nxt = S_HIGH;
            else if (cnt_r == `BIS_MAX_BIT_CYC)
               state_nxt = S_IDLE;
         end
         S_HIGH: begin
            // Seven high bits (at least six bit times) then the low eighth data bit
            if (fall && cnt_r >= (low_r << 2) + (low_r << 1))
               state_nxt = S_DONE;
            else if (fall)
               state_nxt = S_LOW;
         end
         S_DONE: state_nxt = S_DONE;
         default: state_nxt = S_IDLE;
      endcase
      if (!enable)
         state_nxt = S_IDLE;
   end

   // Edge-to-edge saturating period counter and captured bit length
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r   <= S_IDLE;
         cnt_r     <= {`BIS_CNT_W{1'b0}};
         low_r     <= {`BIS_CNT_W{1'b0}};
         rx_d_r    <= 1'b1;
         found_r   <= 1'b0;
         bit_cyc_r <= {`BIS_CNT_W{1'b0}};
      end else begin
         state_r <= state_nxt;
         rx_d_r  <= rx;
         if (fall || rise)
            cnt_r <= {`BIS_CNT_W{1'b0}};
         else if (cnt_r != {`BIS_CNT_W{1'b1}})
            cnt_r <= cnt_r + 1'b1;
         if (state_r == S_LOW && rise)
            low_r <= cnt_r + 1'b1;
         if (state_nxt == S_DONE && state_r != S_DONE) begin
            found_r   <= 1'b1;
            bit_cyc_r <= low_r;
         end
         if (!enable)
            found_r <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ===== design/bis_map.vh
// Constants of the boot interface selector: register offsets, fields,
// reset values and timing counts.
// Assumes a 10 MHz pclk and a 32-bit APB slave port.
`ifndef BIS_MAP_VH
`define BIS_MAP_VH

// Register byte offsets
`define BIS_CTRL_OFF       12'h000
`define BIS_STAT_OFF       12'h004
`define BIS_BAUD_OFF       12'h008
`define BIS_PROT_OFF       12'h00C
`define BIS_OPT_OFF        12'h010

// Control fields
`define BIS_CTRL_RESTART   0
`define BIS_CTRL_PROTECT   1
`define BIS_CTRL_UNPROTECT 2

// Status field positions
`define BIS_SF_LOADER      0
`define BIS_SF_SEL_LSB     1
`define BIS_SF_SEL_MSB     3
`define BIS_SF_BAUD_OK     4
`define BIS_SF_STATE_LSB   8

// Selected link codes (one-hot)
`define BIS_LINK_NONE      3'h0
`define BIS_LINK_SER1      3'h1
`define BIS_LINK_SER2      3'h2
`define BIS_LINK_USB       3'h4

// Protection levels
`define BIS_PROT_L0        2'h0
`define BIS_PROT_L1        2'h1

// Sync byte looked for on the serial ports
`define BIS_SYNC_BYTE      8'h7F

// Option byte reset value: boot source option bit set
`define BIS_OPT_RESET      8'h01

// Timing: clock period in ns, longest serial bit in us
`define BIS_CLK_NS         100
`define BIS_MAX_BIT_US     1000
`define BIS_MAX_BIT_CYC    ((`BIS_MAX_BIT_US * 1000) / `BIS_CLK_NS)
`define BIS_CNT_W          16

`endif

// ===== design/bis_top.v
// Boot interface selector: loader entry and link auto-selection.
// Assumes APB master on pclk; link pins synchronous to pclk.
//
// Functional notes
// - Loader entry needs boot pin and option bit
// - Serial clock, CTS, RTS pins left unused
// - Poll three links endlessly until chosen
// - Sync byte selects port, then auto-baud
// - USB attach with ext_clock_ok during selection selects USB
// - After selection other links are disabled
// - Later USB attach leaves serial session
// - Protect sets level 1, unprotect level 0
// - Serial link is 8 bits, even, one stop
`timescale 1ns/1ps
`default_nettype none
`include "bis_map.vh"

module bis_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        boot_select_pin,
   input  wire        first_serial_receive,
   input  wire        second_serial_receive,
   input  wire        usb_attach,
   input  wire        ext_clock_ok,
   input  wire        system_reset_req,
   output reg         loader_mode_r,
   output reg         first_serial_en_r,
   output reg         second_serial_en_r,
   output reg         usb_en_r,
   output reg  [1:0]  prot_level_r,
   output reg  [7:0]  serial_frame_cfg_r
);

   localparam [4:0] S_STRAP = 5'b00001;
   localparam [4:0] S_APP   = 5'b00010;
   localparam [4:0] S_POLL  = 5'b00100;
   localparam [4:0] S_SER   = 5'b01000;
   localparam [4:0] S_USB   = 5'b10000;

   // Frame config: [3:0] data bits, [4] parity on, [5] even, [6] 1 stop
   localparam [7:0] FRAME_8E1 = 8'h78;

   reg  [4:0]            state_r;
   reg  [4:0]            state_nxt;
   reg  [2:0]            sel_r;
   reg  [`BIS_CNT_W-1:0] baud_r;
   reg                   baud_ok_r;
   reg  [7:0]            opt_r;
   wire                  found1;
   wire                  found2;
   wire [`BIS_CNT_W-1:0] cyc1;
   wire [`BIS_CNT_W-1:0] cyc2;
   wire                  polling;
   wire                  wr_en;
   wire                  rd_en;
   wire                  usb_ready;

   assign polling   = (state_r == S_POLL);
   assign wr_en     = psel & penable & pwrite;
   assign rd_en     = psel & penable & ~pwrite;
   assign usb_ready = usb_attach & ext_clock_ok;

   // Watchers only run while the loop is polling
   bis_auto_baud u_ser1 (
      .pclk      (pclk),
      .presetn   (presetn),
      .enable    (polling),
      .rx        (first_serial_receive),
      .found_r   (found1),
      .bit_cyc_r (cyc1)
   );

   bis_auto_baud u_ser2 (
      .pclk      (pclk),
      .presetn   (presetn),
      .enable    (polling),
      .rx        (second_serial_receive),
      .found_r   (found2),
      .bit_cyc_r (cyc2)
   );

   // Selection state machine
   always @* begin
      state_nxt = state_r;
      case (state_r)
         // Strap sampled one edge after reset release
         S_STRAP: begin
            if (boot_select_pin && opt_r[0])
               state_nxt = S_POLL;
            else
               state_nxt = S_APP;
         end
         S_APP: state_nxt = S_APP;
         // Endless loop over all three links
         S_POLL: begin
            if (usb_ready)
               state_nxt = S_USB;
            else if (found1 || found2)
               state_nxt = S_SER;
         end
         // USB attach ignored; only system reset leaves
         S_SER: if (system_reset_req) state_nxt = S_STRAP;
         S_USB: if (system_reset_req) state_nxt = S_STRAP;
         default: state_nxt = S_STRAP;
      endcase
   end

   // Link choice, enables and captured baud
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r            <= S_STRAP;
         sel_r              <= `BIS_LINK_NONE;
         baud_r             <= {`BIS_CNT_W{1'b0}};
         baud_ok_r          <= 1'b0;
         loader_mode_r      <= 1'b0;
         first_serial_en_r  <= 1'b0;
         second_serial_en_r <= 1'b0;
         usb_en_r           <= 1'b0;
         serial_frame_cfg_r <= 8'h00;
      end else begin
         state_r       <= state_nxt;
         loader_mode_r <= (state_nxt == S_POLL) || (state_nxt == S_SER) ||
                          (state_nxt == S_USB);
         if (state_r == S_POLL && state_nxt == S_SER) begin
            // Port 1 wins a same-cycle tie with port 2
            if (found1) begin
               sel_r  <= `BIS_LINK_SER1;
               baud_r <= cyc1;
            end else begin
               sel_r  <= `BIS_LINK_SER2;
               baud_r <= cyc2;
            end
            baud_ok_r <= 1'b1;
         end else if (state_r == S_POLL && state_nxt == S_USB) begin
            sel_r <= `BIS_LINK_USB;
         end else if (state_nxt == S_STRAP) begin
            sel_r     <= `BIS_LINK_NONE;
            baud_ok_r <= 1'b0;
         end
         // Only the chosen link stays enabled
         first_serial_en_r  <= (state_nxt == S_POLL) ||
                               (state_nxt == S_SER && (sel_r[0] ||
                               (state_r == S_POLL && found1)));
         second_serial_en_r <= (state_nxt == S_POLL) ||
                               (state_nxt == S_SER && (sel_r[1] ||
                               (state_r == S_POLL && !found1)));
         usb_en_r           <= (state_nxt == S_POLL) ||
                               (state_nxt == S_USB);
         // Serial frame fixed to 8 data, even parity, one stop
         serial_frame_cfg_r <= (state_nxt == S_SER) ? FRAME_8E1 : 8'h00;
         // No clock, CTS or RTS pin is driven by the loader
      end
   end

   // Option byte and protection level, written over APB
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_r        <= `BIS_OPT_RESET;
         prot_level_r <= `BIS_PROT_L0;
      end else if (wr_en && pready) begin
         if (paddr == `BIS_OPT_OFF)
            opt_r <= pwdata[7:0];
         if (paddr == `BIS_CTRL_OFF) begin
            if (pwdata[`BIS_CTRL_PROTECT])
               prot_level_r <= `BIS_PROT_L1;
            else if (pwdata[`BIS_CTRL_UNPROTECT])
               prot_level_r <= `BIS_PROT_L0;
         end
      end
   end

   // APB slave: pready in first access cycle, error on unmapped address
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            case (paddr)
               `BIS_CTRL_OFF: prdata <= 32'h0000_0000;
               `BIS_STAT_OFF: begin
                  if (!pwrite) begin
                     prdata[`BIS_SF_LOADER] <= loader_mode_r;
                     prdata[`BIS_SF_SEL_MSB:`BIS_SF_SEL_LSB] <= sel_r;
                     prdata[`BIS_SF_BAUD_OK] <= baud_ok_r;
                     prdata[`BIS_SF_STATE_LSB+4:`BIS_SF_STATE_LSB] <= state_r;
                  end else
                     pslverr <= 1'b1;
               end
               `BIS_BAUD_OFF: begin
                  prdata[`BIS_CNT_W-1:0] <= baud_r;
                  pslverr <= pwrite;
               end
               `BIS_PROT_OFF: begin
                  prdata[1:0] <= prot_level_r;
                  pslverr <= pwrite;
               end
               `BIS_OPT_OFF: prdata[7:0] <= opt_r;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

endmodule

`default_nettype wire
